// ### logic/bsc_consts.svh
/*
  Constants of the battery switch-over control: register offsets, field
  positions, reset values, policy codes and timestamp set.
  Assumes inclusion by bare name from design files of this block.
*/
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// register port widths
`define BSC_ADDR_W 4
`define BSC_DATA_W 8

// register offsets
`define BSC_REG_CTRL 4'h0
`define BSC_REG_STATUS 4'h1
`define BSC_REG_IRQ_STAT 4'h2
`define BSC_REG_IRQ_MASK 4'h3

// control register fields
`define BSC_CTRL_POLICY_LSB 0
`define BSC_CTRL_POLICY_MSB 2
`define BSC_CTRL_SW_IRQ_EN 3
`define BSC_CTRL_STAMP_EN 4
`define BSC_CTRL_LOW_IRQ_EN 5

// status register fields
`define BSC_STAT_SWITCH_FLAG 0
`define BSC_STAT_LOW_FLAG 1
`define BSC_STAT_ON_BATTERY 2
`define BSC_STAT_LOW_DET_EN 3

// interrupt status and mask fields
`define BSC_IRQ_SWITCH 0
`define BSC_IRQ_LOW 1
`define BSC_IRQ_RETURN 2
`define BSC_IRQ_W 3

// reset values
`define BSC_POLICY_RST 3'h7
`define BSC_IRQ_MASK_RST 3'h0

// policy field codes
`define BSC_PM_STD_LOW 3'h0
`define BSC_PM_STD_A 3'h1
`define BSC_PM_STD_B 3'h2
`define BSC_PM_DIR_LOW 3'h3
`define BSC_PM_DIR_A 3'h4
`define BSC_PM_DIR_B 3'h5
`define BSC_PM_OFF_A 3'h6
`define BSC_PM_OFF_B 3'h7

// timestamp set selected by a switch to battery
`define BSC_STAMP_SET 3'h4

`endif

// ### logic/bsc_pkg.sv
/*
  Types of the battery switch-over control.
  Assumes nothing of its surroundings.
*/
package bsc_pkg;

  // switch-over mode decoded from the policy field
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_OFF = 2'b10
  } bsc_mode_t;

  // which supply feeds the internal rail
  typedef enum logic {
    SUP_MAIN = 1'b0,
    SUP_BATTERY = 1'b1
  } bsc_supply_t;

endpackage : bsc_pkg

// ### logic/bsc_policy_dec.sv
/*
  Decodes the three-bit supply policy field into switch-over mode and
  low-detect enable. Assumes the field is a stable register output.
*/
`timescale 1ns/100ps
`default_nettype none

`include "bsc_consts.svh"

module bsc_policy_dec (
  bsc_policy_if.dec pol  // field in, mode and low-detect enable out
);

  // RQ1 field to mode
  always_comb begin
    unique case (pol.supplyPolicyField)
      `BSC_PM_STD_LOW, `BSC_PM_STD_A, `BSC_PM_STD_B:
        pol.mode = bsc_pkg::MODE_STANDARD;
      `BSC_PM_DIR_LOW, `BSC_PM_DIR_A, `BSC_PM_DIR_B:
        pol.mode = bsc_pkg::MODE_DIRECT;
      `BSC_PM_OFF_A, `BSC_PM_OFF_B:
        pol.mode = bsc_pkg::MODE_OFF;
    endcase
  end

  // RQ2 low detect only on two codes
  assign pol.lowDetectEnable =
    (pol.supplyPolicyField == `BSC_PM_STD_LOW) ||
    (pol.supplyPolicyField == `BSC_PM_DIR_LOW);

endmodule : bsc_policy_dec

`default_nettype wire

// ### logic/bsc_policy_if.sv
/*
  Carries the policy field to its decoder and the decoded mode back.
  Assumes one clock domain; purely combinational content.
*/
`timescale 1ns/100ps
`default_nettype none

interface bsc_policy_if;
  logic [2:0] supplyPolicyField;
  bsc_pkg::bsc_mode_t mode;
  logic lowDetectEnable;

  modport dec (input supplyPolicyField, output mode, output lowDetectEnable);
  modport top (output supplyPolicyField, input mode, input lowDetectEnable);
endinterface : bsc_policy_if

`default_nettype wire

// ### logic/bsc_switchover_ctrl.sv
/*
  Battery switch-over control: supply selection from synchronised
  comparator levels, switch and battery-low flags, event interrupt,
  timestamp trigger, and gating of the host port and square wave while
  running from the battery.
  Assumes comparators are asynchronous to clk, the square wave source and
  the host register port run on clk, and rst_n is synchronous, low.
*/
// Operation
// RQ1: policy field selects standard, direct or off
// RQ2: low detect only for codes 000, 011
// RQ3: reset policy disables switch-over and low detect
// RQ4: standard mode fails on both comparators low
// RQ5: direct mode fails on supply below battery
// RQ6: switch to battery sets switch flag
// RQ7: switch interrupt only when its enable set
// RQ8: switch with stamp enable triggers capture four
// RQ9: switch flag sticky until host clears it
// RQ10: on battery ignore host, stop square wave
// RQ11: on battery host outputs go high-impedance
// RQ12: switch-over off keeps main, flag zero
// RQ13: low detect sets low flag when battery low
// RQ14: low check continues while on battery
// RQ15: low interrupt only when its enable set
// RQ16: low flag host-clear ignored, auto-clears
// RQ17: flag sets on rising selection, write 0 clears
// RQ18: comparators pass synchroniser before use
`timescale 1ns/100ps
`default_nettype none

`include "bsc_consts.svh"

module bsc_switchover_ctrl (
  input wire logic clk,                        // block clock, 40 MHz
  input wire logic rst_n,                      // synchronous reset, low
  input wire logic [`BSC_ADDR_W-1:0] regAddr,  // register address
  input wire logic [`BSC_DATA_W-1:0] regWdata, // register write data
  input wire logic regWr,                      // write strobe
  input wire logic regRd,                      // read strobe
  output logic [`BSC_DATA_W-1:0] regRdata,     // read data, next cycle
  output logic regRdataOe,                     // read data drive enable
  input wire logic vddBelowBatAsync,           // main below battery
  input wire logic vddBelowThrAsync,           // main below threshold
  input wire logic batLowAsync,                // battery below low level
  input wire logic squareWaveIn,               // divided clock source
  output logic squareWaveOut,                  // square wave pin value
  output logic squareWaveOe,                   // square wave drive enable
  output logic backedSupplySel,                // 1: rail on battery
  output logic thresholdMonEn,                 // threshold comparator on
  output logic lowDetectEn,                    // low comparator on
  output logic stampCapture,                   // capture pulse
  output logic [2:0] stampSet,                 // set for the capture
  output logic irqOut                          // level interrupt
);

  // ---- synchronised comparator levels
  logic vddBelowBat;
  logic vddBelowThr;
  logic batLow;

  // RQ18 synchronise each comparator
  bsc_sync syncBelowBat (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(vddBelowBatAsync),
    .level(vddBelowBat)
  );

  bsc_sync syncBelowThr (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(vddBelowThrAsync),
    .level(vddBelowThr)
  );

  bsc_sync syncBatLow (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(batLowAsync),
    .level(batLow)
  );

  // ---- control register state
  logic [2:0] supplyPolicyField_q;
  logic batterySwitchIrqEnable_q;
  logic batterySwitchStampEnable_q;
  logic batteryLowIrqEnable_q;
  logic [`BSC_IRQ_W-1:0] irqMask_q;

  // ---- flags, supply state, interrupt status
  bsc_pkg::bsc_supply_t supState_q;
  bsc_pkg::bsc_supply_t supState_d;
  logic batterySwitchFlag_q;
  logic batteryLowFlag_q;
  logic [`BSC_IRQ_W-1:0] irqStat_q;
  logic [`BSC_IRQ_W-1:0] irqSet;

  // ---- output registers
  logic [`BSC_DATA_W-1:0] regRdata_q;
  logic regRdataOe_q;
  logic squareWaveOut_q;
  logic squareWaveOe_q;
  logic thresholdMonEn_q;
  logic lowDetectEn_q;
  logic stampCapture_q;
  logic irqOut_q;

  // ---- policy decoder
  bsc_policy_if pol ();
  bsc_pkg::bsc_mode_t mode;
  logic lowDetEnable;

  assign pol.supplyPolicyField = supplyPolicyField_q;
  assign mode = pol.mode;
  assign lowDetEnable = pol.lowDetectEnable;

  bsc_policy_dec policyDec (
    .pol(pol.dec)
  );

  // ---- host access, gated while on battery
  logic hostEnabled;
  logic wrEn;
  logic rdEn;

  // RQ10 host strobes ignored on battery
  assign hostEnabled = (supState_q == bsc_pkg::SUP_MAIN);
  assign wrEn = regWr && hostEnabled;
  assign rdEn = regRd && hostEnabled;

  // ---- supply failure decision
  logic supplyFail;

  // failure condition per mode
  always_comb begin
    unique case (mode)
      // RQ4 both comparators must agree
      bsc_pkg::MODE_STANDARD: supplyFail = vddBelowBat && vddBelowThr;
      // RQ5 threshold comparison not consulted
      bsc_pkg::MODE_DIRECT: supplyFail = vddBelowBat;
      // RQ12 never fail over when off
      bsc_pkg::MODE_OFF: supplyFail = 1'b0;
      default: supplyFail = 1'b0;
    endcase
  end

  // ---- supply state machine
  always_comb begin
    supState_d = supState_q;
    unique case (supState_q)
      bsc_pkg::SUP_MAIN: begin
        if (supplyFail) begin
          supState_d = bsc_pkg::SUP_BATTERY;
        end
      end
      bsc_pkg::SUP_BATTERY: begin
        if (!supplyFail) begin
          supState_d = bsc_pkg::SUP_MAIN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supState_q <= bsc_pkg::SUP_MAIN;
    end else begin
      supState_q <= supState_d;
    end
  end

  // ---- switch and return events
  logic switchEvent;
  logic returnEvent;

  // RQ17 only the main-to-battery edge
  assign switchEvent = (supState_q == bsc_pkg::SUP_MAIN) &&
                       (supState_d == bsc_pkg::SUP_BATTERY);
  assign returnEvent = (supState_q == bsc_pkg::SUP_BATTERY) &&
                       (supState_d == bsc_pkg::SUP_MAIN);

  // ---- control register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // RQ3 reset code disables switch-over
      supplyPolicyField_q <= `BSC_POLICY_RST;
      batterySwitchIrqEnable_q <= 1'b0;
      batterySwitchStampEnable_q <= 1'b0;
      batteryLowIrqEnable_q <= 1'b0;
    end else if (wrEn && regAddr == `BSC_REG_CTRL) begin
      supplyPolicyField_q <=
        regWdata[`BSC_CTRL_POLICY_MSB:`BSC_CTRL_POLICY_LSB];
      batterySwitchIrqEnable_q <= regWdata[`BSC_CTRL_SW_IRQ_EN];
      batterySwitchStampEnable_q <= regWdata[`BSC_CTRL_STAMP_EN];
      batteryLowIrqEnable_q <= regWdata[`BSC_CTRL_LOW_IRQ_EN];
    end
  end

  // ---- interrupt mask register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqMask_q <= `BSC_IRQ_MASK_RST;
    end else if (wrEn && regAddr == `BSC_REG_IRQ_MASK) begin
      irqMask_q <= regWdata[`BSC_IRQ_W-1:0];
    end
  end

  // ---- battery switch flag
  logic switchFlagClear;

  // RQ17 write of zero clears, one ignored
  assign switchFlagClear = wrEn && (regAddr == `BSC_REG_STATUS) &&
                           !regWdata[`BSC_STAT_SWITCH_FLAG];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      batterySwitchFlag_q <= 1'b0;
    end else if (mode == bsc_pkg::MODE_OFF) begin
      // RQ12 flag held at zero
      batterySwitchFlag_q <= 1'b0;
    end else if (switchEvent) begin
      // RQ6 set on switch, wins over clear
      batterySwitchFlag_q <= 1'b1;
    end else if (switchFlagClear) begin
      // RQ9 sticky until host clears
      batterySwitchFlag_q <= 1'b0;
    end
  end

  // ---- battery low flag
  // RQ13 set while enabled and low
  // RQ14 evaluated on either supply
  // RQ16 no host clear, follows comparator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      batteryLowFlag_q <= 1'b0;
    end else begin
      batteryLowFlag_q <= lowDetEnable && batLow;
    end
  end

  // ---- interrupt status sources
  always_comb begin
    irqSet = '0;
    // RQ7 switch interrupt gated by enable
    // RQ9 re-asserts while flag stays set
    irqSet[`BSC_IRQ_SWITCH] = batterySwitchFlag_q &&
                              batterySwitchIrqEnable_q;
    // RQ15 low interrupt gated by enable
    irqSet[`BSC_IRQ_LOW] = batteryLowFlag_q && batteryLowIrqEnable_q;
    irqSet[`BSC_IRQ_RETURN] = returnEvent;
  end

  // sticky status, read clears, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_q <= '0;
    end else if (rdEn && regAddr == `BSC_REG_IRQ_STAT) begin
      irqStat_q <= irqSet;
    end else begin
      irqStat_q <= irqStat_q | irqSet;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqOut_q <= 1'b0;
    end else begin
      irqOut_q <= |(irqStat_q & irqMask_q);
    end
  end

  // ---- timestamp trigger
  // RQ8 capture pulse on switch when enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stampCapture_q <= 1'b0;
    end else begin
      stampCapture_q <= switchEvent && batterySwitchStampEnable_q;
    end
  end

  // ---- read data mux
  logic [`BSC_DATA_W-1:0] rdMux;

  always_comb begin
    rdMux = '0;
    unique case (regAddr)
      `BSC_REG_CTRL: begin
        rdMux[`BSC_CTRL_POLICY_MSB:`BSC_CTRL_POLICY_LSB] =
          supplyPolicyField_q;
        rdMux[`BSC_CTRL_SW_IRQ_EN] = batterySwitchIrqEnable_q;
        rdMux[`BSC_CTRL_STAMP_EN] = batterySwitchStampEnable_q;
        rdMux[`BSC_CTRL_LOW_IRQ_EN] = batteryLowIrqEnable_q;
      end
      `BSC_REG_STATUS: begin
        rdMux[`BSC_STAT_SWITCH_FLAG] = batterySwitchFlag_q;
        rdMux[`BSC_STAT_LOW_FLAG] = batteryLowFlag_q;
        rdMux[`BSC_STAT_ON_BATTERY] = (supState_q == bsc_pkg::SUP_BATTERY);
        rdMux[`BSC_STAT_LOW_DET_EN] = lowDetEnable;
      end
      `BSC_REG_IRQ_STAT: rdMux[`BSC_IRQ_W-1:0] = irqStat_q;
      `BSC_REG_IRQ_MASK: rdMux[`BSC_IRQ_W-1:0] = irqMask_q;
      default: rdMux = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata_q <= '0;
    end else if (rdEn) begin
      regRdata_q <= rdMux;
    end else begin
      regRdata_q <= '0;
    end
  end

  // RQ11 release host outputs on battery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdataOe_q <= 1'b1;
    end else begin
      regRdataOe_q <= (supState_d == bsc_pkg::SUP_MAIN);
    end
  end

  // RQ10 square wave off on battery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      squareWaveOut_q <= 1'b0;
      squareWaveOe_q <= 1'b1;
    end else if (supState_d == bsc_pkg::SUP_BATTERY) begin
      squareWaveOut_q <= 1'b0;
      squareWaveOe_q <= 1'b0;
    end else begin
      squareWaveOut_q <= squareWaveIn;
      squareWaveOe_q <= 1'b1;
    end
  end

  // RQ5 threshold monitor only in standard mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thresholdMonEn_q <= 1'b0;
      lowDetectEn_q <= 1'b0;
    end else begin
      thresholdMonEn_q <= (mode == bsc_pkg::MODE_STANDARD);
      lowDetectEn_q <= lowDetEnable;
    end
  end

  // ---- outputs
  assign regRdata = regRdata_q;
  assign regRdataOe = regRdataOe_q;
  assign squareWaveOut = squareWaveOut_q;
  assign squareWaveOe = squareWaveOe_q;
  assign backedSupplySel = supState_q;
  assign thresholdMonEn = thresholdMonEn_q;
  assign lowDetectEn = lowDetectEn_q;
  assign stampCapture = stampCapture_q;
  assign stampSet = `BSC_STAMP_SET;
  assign irqOut = irqOut_q;

endmodule : bsc_switchover_ctrl

`default_nettype wire

// ### logic/bsc_sync.sv
/*
  Three-stage synchroniser for one asynchronous comparator output.
  A new level is taken once the second and third stages agree.
  Assumes clk is the block clock and rst_n a synchronous low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module bsc_sync (
  input wire logic clk,      // block clock
  input wire logic rst_n,    // synchronous reset, low
  input wire logic asyncIn,  // comparator output, unsynchronised
  output logic level         // filtered synchronous level
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  // RQ18 three flops in chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // accept a change only when stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (stage2_q == stage3_q) begin
      level_q <= stage3_q;
    end
  end

  assign level = level_q;

endmodule : bsc_sync

`default_nettype wire

// ### verification/battery_switchover_control_bench.sv
/*
  Self-checking bench of the battery switch-over control.
  Assumes the comparator model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none

module battery_switchover_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic squareWaveIn = 1'b0;
  logic wantBat = 1'b0;
  logic wantThr = 1'b0;
  logic wantLow = 1'b0;
  logic [7:0] regRdata;
  logic [2:0] stampSet;
  logic regRdataOe, squareWaveOut, squareWaveOe, backedSupplySel;
  logic thresholdMonEn, lowDetectEn, stampCapture, irqOut;
  logic vddBelowBatAsync, vddBelowThrAsync, batLowAsync;
  logic [7:0] stamps = 8'h00;
  logic [7:0] seed = 8'h23;
  logic [7:0] d;
  int err_total = 0;
  int num_checks = 0;

  bsc_switchover_ctrl bsc_switchover_ctrl_i (.clk, .rst_n, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .regRdataOe, .vddBelowBatAsync,
    .vddBelowThrAsync, .batLowAsync, .squareWaveIn, .squareWaveOut,
    .squareWaveOe, .backedSupplySel, .thresholdMonEn, .lowDetectEn,
    .stampCapture, .stampSet, .irqOut);
  bsc_supply_model bsc_supply_model_i (.wantBat, .wantThr, .wantLow,
    .belowBat(vddBelowBatAsync), .belowThr(vddBelowThrAsync),
    .batLow(batLowAsync));

  // clock, toggling source, capture counter
  always #12.5 clk = ~clk;
  always @(posedge clk) squareWaveIn <= ~squareWaveIn;
  always @(posedge clk) if (stampCapture === 1'b1) stamps <= stamps + 8'h01;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic lowOn(input logic [2:0] c);
    return c == 3'h0 || c == 3'h3;
  endfunction : lowOn
  function automatic logic selFor(input logic [2:0] c, input logic t);
    return (c < 3'h3) ? t : (c < 3'h6);
  endfunction : selFor

  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task chkR(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chkR
  task chkP(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chkP
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // watchdog, about four times the expected run of some 490 cycles
  initial begin
    #50000;
    err_total++;
    complete_run();
  end

  initial begin
    logic [2:0] c;
    logic ie, se, e;
    logic [7:0] sb;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h0, d);
    chkR("ctrl", 8'h07, d);
    rd(4'h1, d);
    chkR("status", 8'h00, d);
    chkP("lowEn", 1'b0, lowDetectEn);
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chkR("unmapped", 8'h00, d);
    wr(4'h3, 8'h01);
    // every policy code, random enables
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      seed = lfsr(seed);
      ie = seed[0];
      se = seed[1];
      wr(4'h0, {3'h0, se, ie, c});
      wt(2);
      chkP("lowEn", lowOn(c), lowDetectEn);
      chkP("thrEn", c < 3'h3, thresholdMonEn);
      sb = stamps;
      wantBat <= 1'b1;
      wt(10);
      chkP("selBat", selFor(c, 1'b0), backedSupplySel);
      wantThr <= 1'b1;
      wt(10);
      e = selFor(c, 1'b1);
      chkP("sel", e, backedSupplySel);
      chkP("rdOe", !e, regRdataOe);
      chkP("sqw", e ? 1'b0 : ~squareWaveIn, squareWaveOut);
      chkP("sqwOe", !e, squareWaveOe);
      chkP("irq", e & ie, irqOut);
      chkR("stamps", {7'h0, e & se}, stamps - sb);
      wr(4'h0, 8'h07);
      wantBat <= 1'b0;
      wantThr <= 1'b0;
      wt(10);
      rd(4'h0, d);
      chkR("ctrl", e ? {3'h0, se, ie, c} : 8'h07, d);
      rd(4'h1, d);
      chkR("status", {4'h0, e & lowOn(c), 2'h0, e}, d);
      wr(4'h1, 8'h01);
      rd(4'h1, d);
      chkR("flagHeld", {4'h0, e & lowOn(c), 2'h0, e}, d);
      chkP("irqHeld", e & ie, irqOut);
      wr(4'h1, 8'h00);
      rd(4'h2, d);
      chkR("irqStat", {5'h0, e, 1'b0, e & ie}, d);
      wt(2);
      chkP("irqClr", 1'b0, irqOut);
    end
    // battery low detection
    wr(4'h0, 8'h21);
    wantLow <= 1'b1;
    wt(10);
    rd(4'h1, d);
    chkR("lowOff", 8'h00, d);
    wr(4'h0, 8'h20);
    wr(4'h3, 8'h02);
    wt(10);
    chkP("lowIrq", 1'b1, irqOut);
    rd(4'h1, d);
    chkR("lowSet", 8'h0A, d);
    wr(4'h1, 8'h00);
    rd(4'h1, d);
    chkR("lowKept", 8'h0A, d);
    wantLow <= 1'b0;
    wt(10);
    rd(4'h1, d);
    chkR("lowGone", 8'h08, d);
    rd(4'h2, d);
    chkR("irqStat", 8'h02, d);
    wantBat <= 1'b1;
    wantThr <= 1'b1;
    wt(10);
    wantLow <= 1'b1;
    wt(10);
    wantBat <= 1'b0;
    wantThr <= 1'b0;
    wt(10);
    rd(4'h1, d);
    chkR("lowOnBat", 8'h0B, d);
    complete_run();
  end
endmodule : battery_switchover_control_bench

`default_nettype wire

// ### verification/bsc_supply_model.sv
/*
  Model of the supply comparators at the block's far side.
  Assumes the bench sets the wanted supply conditions.
*/
`timescale 1ns/100ps
`default_nettype none

module bsc_supply_model (
  input wire logic wantBat,  // main shall fall below battery
  input wire logic wantThr,  // main shall fall below threshold
  input wire logic wantLow,  // battery shall fall below low level
  output logic belowBat,     // comparator, main below battery
  output logic belowThr,     // comparator, main below threshold
  output logic batLow        // comparator, battery low
);
  // idle levels at power-up
  initial begin
    belowBat = 1'b0;
    belowThr = 1'b0;
    batLow = 1'b0;
  end
  always @(wantBat) belowBat <= #7 wantBat;
  always @(wantThr) belowThr <= #9 wantThr;
  always @(wantLow) batLow <= #11 wantLow;
endmodule : bsc_supply_model

`default_nettype wire

// ### verification/bsc_switchover_monitor.sv
/*
  Port checker of the battery switch-over control.
  Assumes one clock domain and rst_n synchronous, low.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bsc_consts.svh"

module bsc_switchover_monitor (
  input wire logic clk,                    // block clock
  input wire logic rst_n,                  // reset, low
  input wire logic regRd,                  // read strobe
  input wire logic [`BSC_DATA_W-1:0] regRdata, // read data
  input wire logic regRdataOe,             // read data enable
  input wire logic vddBelowBatAsync,       // main below battery
  input wire logic vddBelowThrAsync,       // main below threshold
  input wire logic squareWaveOut,          // square wave pin
  input wire logic squareWaveOe,           // square wave enable
  input wire logic backedSupplySel,        // rail on battery
  input wire logic thresholdMonEn,         // threshold monitor on
  input wire logic stampCapture,           // capture pulse
  input wire logic [2:0] stampSet,         // capture set
  input wire logic irqOut                  // interrupt level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // square wave and host port gated on battery
  property p_sqw_off;
    backedSupplySel |-> !squareWaveOe && !squareWaveOut;
  endproperty
  a_sqw_off: assert property (p_sqw_off)
    else $error("square wave on battery");
  property p_host_hiz;
    backedSupplySel |-> !regRdataOe;
  endproperty
  a_host_hiz: assert property (p_host_hiz)
    else $error("host port driven");
  property p_rd_idle;
    !$past(regRd && !backedSupplySel) |-> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data unasked");
  // capture only at the switching edge, into set four
  property p_stamp_sw;
    stampCapture |-> $rose(backedSupplySel) && stampSet == `BSC_STAMP_SET;
  endproperty
  a_stamp_sw: assert property (p_stamp_sw)
    else $error("capture off switch");
  property p_stamp_pulse;
    stampCapture |=> !stampCapture;
  endproperty
  a_stamp_pulse: assert property (p_stamp_pulse)
    else $error("capture too long");
  // no battery without main below battery
  property p_no_bat;
    !vddBelowBatAsync [*8] |-> !backedSupplySel;
  endproperty
  a_no_bat: assert property (p_no_bat)
    else $error("battery w/o failure");
  property p_std_thr;
    (thresholdMonEn && !vddBelowThrAsync) [*8] |-> !backedSupplySel;
  endproperty
  a_std_thr: assert property (p_std_thr)
    else $error("threshold ignored");
  // a switch needs the comparator level held through the chain
  property p_sync;
    $rose(backedSupplySel) |->
      $past(vddBelowBatAsync, 3) && $past(vddBelowBatAsync, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("switch too early");

  c_switch: cover property ($rose(backedSupplySel));
  c_stamp: cover property (stampCapture);
  c_irq: cover property ($rose(irqOut));
endmodule : bsc_switchover_monitor

bind bsc_switchover_ctrl bsc_switchover_monitor bsc_switchover_monitor_i (
  .clk, .rst_n, .regRd, .regRdata, .regRdataOe, .vddBelowBatAsync,
  .vddBelowThrAsync, .squareWaveOut, .squareWaveOe, .backedSupplySel,
  .thresholdMonEn, .stampCapture, .stampSet, .irqOut
);

`default_nettype wire
